/* core/event_array_defines.svh */
// Constants for the event capture/compare channel array
`ifndef EVENT_ARRAY_DEFINES_SVH
`define EVENT_ARRAY_DEFINES_SVH
`define EA_TW          16
`define EA_NUM_CAP     10
`define EA_NUM_CH      12
`define EA_NUM_DIRECT  4
`define EA_NUM_SRC     8
`define EA_NUM_MAIN    5
`define EA_MUX_BIT     4
`define EA_CHAN_W      4
`define EA_CTL_W       9
`define EA_CTL_RST     9'h000
`define EA_TIME_RST    16'h0000
`define EA_CTL_OW      0
`define EA_CTL_ADC     1
`define EA_CTL_RST_OWN 2
`define EA_CTL_REEN    3
`define EA_CTL_SEL_LO  4
`define EA_CTL_SEL_HI  5
`define EA_CTL_MODE    6
`define EA_CTL_TSEL    7
`define EA_CTL_RST_OTH 8
`define EA_SHARED_A    8
`define EA_SHARED_B    9
`endif

/* core/event_array_pkg.sv */
// Types for the event capture/compare channel array
`default_nettype none
package event_array_pkg;
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_CLR  = 2'b01,
        ACT_SET  = 2'b10,
        ACT_TGL  = 2'b11
    } action_t;
    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_t;
    typedef enum logic [1:0] {
        CAP_EMPTY = 2'b00,
        CAP_TIME  = 2'b01,
        CAP_BUF   = 2'b10,
        CAP_BOTH  = 2'b11
    } cap_state_t;
endpackage
`default_nettype wire

/* core/cap_if.sv */
// Link between the channel array and one capture unit
`default_nettype none
interface cap_if;
    logic        edge_ok;
    logic        rd;
    logic        ow;
    logic [15:0] tval;
    logic [15:0] time_val;
    logic        xfer;
    logic        ovr;
    modport top  (output edge_ok, rd, ow, tval, input time_val, xfer, ovr);
    modport unit (input edge_ok, rd, ow, tval, output time_val, xfer, ovr);
endinterface
`default_nettype wire

/* core/capture_unit.sv */
// One capture unit: capture buffer ahead of the event-time register
`default_nettype none
`include "event_array_defines.svh"
module capture_unit (
    input  wire logic i_mclk,   // State clock
    input  wire logic i_rst_b,  // Sync reset, active low
    cap_if.unit       cif       // Array side
);
    event_array_pkg::cap_state_t state_ff;
    logic [`EA_TW-1:0]           buf_ff;
    logic [`EA_TW-1:0]           time_ff;
    logic                        xfer_ff;
    logic                        ovr_ff;

    assign cif.time_val = time_ff;
    assign cif.xfer     = xfer_ff;
    assign cif.ovr      = ovr_ff;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_ff <= event_array_pkg::CAP_EMPTY;
            buf_ff   <= `EA_TIME_RST;
            time_ff  <= `EA_TIME_RST;
            xfer_ff  <= 1'b0;
            ovr_ff   <= 1'b0;
        end else begin
            xfer_ff <= 1'b0;
            ovr_ff  <= 1'b0;
            case (state_ff)
                event_array_pkg::CAP_EMPTY: begin
                    if (cif.edge_ok) begin
                        buf_ff   <= cif.tval;
                        state_ff <= event_array_pkg::CAP_BUF;
                    end
                end
                event_array_pkg::CAP_BUF: begin
                    time_ff <= buf_ff;
                    xfer_ff <= 1'b1;
                    if (cif.edge_ok) begin
                        buf_ff   <= cif.tval;
                        state_ff <= event_array_pkg::CAP_BOTH;
                    end else begin
                        state_ff <= event_array_pkg::CAP_TIME;
                    end
                end
                event_array_pkg::CAP_TIME: begin
                    if (cif.edge_ok) begin
                        buf_ff   <= cif.tval;
                        state_ff <= cif.rd ? event_array_pkg::CAP_BUF : event_array_pkg::CAP_BOTH;
                    end else if (cif.rd) begin
                        state_ff <= event_array_pkg::CAP_EMPTY;
                    end
                end
                event_array_pkg::CAP_BOTH: begin
                    if (cif.rd && cif.edge_ok && cif.ow) begin
                        // Read lands on edge validation: transfer lost, both stay full
                        buf_ff <= cif.tval;
                        ovr_ff <= 1'b1;
                    end else if (cif.rd) begin
                        time_ff <= buf_ff;
                        xfer_ff <= 1'b1;
                        if (cif.edge_ok) begin
                            buf_ff <= cif.tval;
                        end else begin
                            state_ff <= event_array_pkg::CAP_TIME;
                        end
                    end else if (cif.edge_ok) begin
                        ovr_ff <= 1'b1;
                        if (cif.ow) begin
                            buf_ff <= cif.tval;
                        end
                    end
                end
                default: state_ff <= event_array_pkg::CAP_EMPTY;
            endcase
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    property p_first_xfer;
        (state_ff == event_array_pkg::CAP_EMPTY && cif.edge_ok) |=> !xfer_ff ##1 xfer_ff;
    endproperty
    a_first_xfer: assert property (p_first_xfer) else $error("capture not moved two cycles after edge");
    property p_drop;
        (state_ff == event_array_pkg::CAP_BOTH && cif.edge_ok && !cif.ow && !cif.rd)
            |=> ovr_ff && !xfer_ff && $stable(buf_ff);
    endproperty
    a_drop: assert property (p_drop) else $error("dropped edge changed buffer or missed overrun");
    property p_overwrite;
        (state_ff == event_array_pkg::CAP_BOTH && cif.edge_ok && cif.ow && !cif.rd)
            |=> ovr_ff && buf_ff == $past(cif.tval);
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("overwrite did not replace buffer");
    property p_read_move;
        (state_ff == event_array_pkg::CAP_BOTH && cif.rd && !cif.edge_ok)
            |=> xfer_ff && time_ff == $past(buf_ff) && state_ff == event_array_pkg::CAP_TIME;
    endproperty
    a_read_move: assert property (p_read_move) else $error("read did not move buffer");
    property p_glitch;
        (state_ff == event_array_pkg::CAP_BOTH && cif.rd && cif.edge_ok && cif.ow)
            |=> state_ff == event_array_pkg::CAP_BOTH && !xfer_ff;
    endproperty
    a_glitch: assert property (p_glitch) else $error("read on edge did not leave both full");
    c_glitch: cover property (state_ff == event_array_pkg::CAP_BOTH && cif.rd && cif.edge_ok && cif.ow);
    c_back_to_back: cover property (xfer_ff ##2 xfer_ff);
endmodule
`default_nettype wire

/* core/event_array_channels.sv */
// Ten capture/compare channels and two compare-only channels
// Function
// - Ten channels, each capture or compare, against a chosen timer.
// - Capture records the chosen timer on the selected pin transition.
// - A/D start request on capture or on compare match.
// - Compare match clears, sets or toggles the pin as configured.
// - Pending flag per capture/compare event; overrun flag on capture overrun.
// - Compare may reset own timer; either mode may reset the other timer.
// - Two compare-only channels with every compare function, no capture.
// - Per channel a control register and an event-time register.
// - Compare-only 0/1 share pins with channels 8/9; the compare-only action is applied after the channel's own.
// - Edge loads the buffer, then moves to event time, setting pending.
// - Edge while register unread waits in buffer; read moves it in.
// - Both full: overwrite bit drops or replaces; overrun set either way.
// - Dropped edge gives no capture, no pending, no transfer; only overrun.
// - Pending is set on transfer into the register, not at edge.
// - Buffered data gives two service requests nearly back to back.
// - Reading the register empties the buffer into it.
// - Read exactly at edge with overwrite leaves both full, no pending.
// - Re-enable bit repeats compare action; clear means once per time write.
// - Buffering only in capture mode; compare has none.
// - Channels 0-3 direct pending bits; others share one multiplexed bit.
`default_nettype none
`include "event_array_defines.svh"
module event_array_channels #(
    parameter int TW = `EA_TW
) (
    input  wire logic                      i_mclk,     // State clock, 200 MHz
    input  wire logic                      i_rst_b,    // Sync reset, active low
    input  wire logic [TW-1:0]             i_timer1,   // Timer 1 value
    input  wire logic [TW-1:0]             i_timer2,   // Timer 2 value
    input  wire logic [`EA_NUM_CAP-1:0]    i_pin,      // Capture pins, asynchronous
    input  wire logic                      i_wr_ctl,   // Control write strobe
    input  wire logic                      i_wr_time,  // Event-time write strobe
    input  wire logic [`EA_CHAN_W-1:0]     i_wr_chan,  // Write channel, 10/11 compare-only
    input  wire logic [TW-1:0]             i_wr_data,  // Write data
    input  wire logic                      i_rd_time,  // Event-time read strobe
    input  wire logic [`EA_CHAN_W-1:0]     i_rd_chan,  // Read channel
    input  wire logic [`EA_NUM_SRC-1:0]    i_src_clr,  // Source pending clear pulses
    input  wire logic [`EA_NUM_CAP-1:0]    i_ovr_clr,  // Overrun pending clear pulses
    input  wire logic [`EA_NUM_MAIN-1:0]   i_main_clr, // Main pending clear pulses
    output logic [TW-1:0]                  o_rd_data,  // Event-time read data
    output logic [`EA_NUM_CAP-1:0]         o_pin,      // Channel output pins
    output logic                           o_adc_start,// A/D start pulse
    output logic                           o_t1_reset, // Timer 1 reset pulse
    output logic                           o_t2_reset, // Timer 2 reset pulse
    output logic [`EA_NUM_MAIN-1:0]        o_main_pend,// Main pending bits
    output logic [`EA_NUM_SRC-1:0]         o_src_pend, // Source pending bits
    output logic [`EA_NUM_CAP-1:0]         o_ovr_pend  // Overrun pending bits
);
    logic [`EA_CTL_W-1:0]          ctl_ff [`EA_NUM_CH];
    logic [TW-1:0]                 cmp_time_ff [`EA_NUM_CH];
    logic [`EA_NUM_CH-1:0]         armed_ff;
    logic [`EA_NUM_CH-1:0]         eq_ff;
    logic [`EA_NUM_CAP-1:0]        pin_s1_ff;
    logic [`EA_NUM_CAP-1:0]        pin_s2_ff;
    logic [`EA_NUM_CAP-1:0]        pin_s3_ff;
    logic [`EA_NUM_CH-1:0]         cmp_mode;
    logic [`EA_NUM_CH-1:0]         match;
    logic [`EA_NUM_CH-1:0]         ev;
    logic [`EA_NUM_CH-1:0]         adc_req;
    logic [`EA_NUM_CH-1:0]         t1_req;
    logic [`EA_NUM_CH-1:0]         t2_req;
    logic [`EA_NUM_CAP-1:0]        cap_ovr;
    logic [TW-1:0]                 cap_time [`EA_NUM_CAP];
    logic [`EA_NUM_CAP-1:0]        nxt_pin;
    logic [TW-1:0]                 o_rd_data_ff;
    logic [`EA_NUM_CAP-1:0]        o_pin_ff;
    logic                          o_adc_start_ff;
    logic                          o_t1_reset_ff;
    logic                          o_t2_reset_ff;
    logic [`EA_NUM_MAIN-1:0]       o_main_pend_ff;
    logic [`EA_NUM_SRC-1:0]        o_src_pend_ff;
    logic [`EA_NUM_CAP-1:0]        o_ovr_pend_ff;

    function automatic logic apply_act(input logic v, input logic [1:0] a);
        case (event_array_pkg::action_t'(a))
            event_array_pkg::ACT_CLR: apply_act = 1'b0;
            event_array_pkg::ACT_SET: apply_act = 1'b1;
            event_array_pkg::ACT_TGL: apply_act = ~v;
            default:                  apply_act = v;
        endcase
    endfunction

    // Pin synchronizer and edge history
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
        end else begin
            pin_s1_ff <= i_pin;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // Channel control and event-time registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            for (int k = 0; k < `EA_NUM_CH; k++) begin
                ctl_ff[k]      <= `EA_CTL_RST;
                cmp_time_ff[k] <= `EA_TIME_RST;
            end
        end else begin
            for (int k = 0; k < `EA_NUM_CH; k++) begin
                if (i_wr_ctl && i_wr_chan == `EA_CHAN_W'(k)) begin
                    ctl_ff[k] <= i_wr_data[`EA_CTL_W-1:0];
                end
                if (i_wr_time && i_wr_chan == `EA_CHAN_W'(k)) begin
                    cmp_time_ff[k] <= i_wr_data;
                end
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < `EA_NUM_CH; i++) begin : g_ch
            logic [TW-1:0] tv;
            logic          eq;
            assign tv          = ctl_ff[i][`EA_CTL_TSEL] ? i_timer2 : i_timer1;
            assign eq          = (tv == cmp_time_ff[i]);
            assign cmp_mode[i] = (i >= `EA_NUM_CAP) || ctl_ff[i][`EA_CTL_MODE];
            assign match[i]    = cmp_mode[i] && armed_ff[i] && eq && !eq_ff[i];
            assign adc_req[i]  = ev[i] && ctl_ff[i][`EA_CTL_ADC];
            // Own-timer reset only on match; other-timer reset on any event
            assign t1_req[i]   = (match[i] && !ctl_ff[i][`EA_CTL_TSEL] && ctl_ff[i][`EA_CTL_RST_OWN]) ||
                                 (ev[i] && ctl_ff[i][`EA_CTL_TSEL] && ctl_ff[i][`EA_CTL_RST_OTH]);
            assign t2_req[i]   = (match[i] && ctl_ff[i][`EA_CTL_TSEL] && ctl_ff[i][`EA_CTL_RST_OWN]) ||
                                 (ev[i] && !ctl_ff[i][`EA_CTL_TSEL] && ctl_ff[i][`EA_CTL_RST_OTH]);

            always_ff @(posedge i_mclk) begin
                if (!i_rst_b) begin
                    armed_ff[i] <= 1'b0;
                    eq_ff[i]    <= 1'b0;
                end else begin
                    eq_ff[i] <= eq;
                    if (i_wr_time && i_wr_chan == `EA_CHAN_W'(i)) begin
                        armed_ff[i] <= 1'b1;
                    end else if (match[i] && !ctl_ff[i][`EA_CTL_REEN]) begin
                        armed_ff[i] <= 1'b0;
                    end
                end
            end

            if (i < `EA_NUM_CAP) begin : g_cap
                cap_if         u_cif ();
                logic          rise;
                logic          fall;
                logic [1:0]    sel;
                assign rise          = pin_s2_ff[i] && !pin_s3_ff[i];
                assign fall          = !pin_s2_ff[i] && pin_s3_ff[i];
                assign sel           = ctl_ff[i][`EA_CTL_SEL_HI:`EA_CTL_SEL_LO];
                assign u_cif.edge_ok = !cmp_mode[i] &&
                    ((rise && sel[0]) || (fall && sel[1]));
                assign u_cif.rd      = i_rd_time && i_rd_chan == `EA_CHAN_W'(i) && !cmp_mode[i];
                assign u_cif.ow      = ctl_ff[i][`EA_CTL_OW];
                assign u_cif.tval    = tv;
                assign cap_time[i]   = u_cif.time_val;
                assign cap_ovr[i]    = u_cif.ovr;
                assign ev[i]         = match[i] || u_cif.xfer;
                capture_unit u_cap (
                    .i_mclk  (i_mclk),
                    .i_rst_b (i_rst_b),
                    .cif     (u_cif.unit)
                );
            end else begin : g_cmp
                assign ev[i] = match[i];
            end
        end
    endgenerate

    // Pin actions; shared pins take both drivers in the same cycle
    generate
        for (i = 0; i < `EA_NUM_CAP; i++) begin : g_pin
            logic [1:0] act_own;
            logic [1:0] act_sh;
            assign act_own = match[i] ? ctl_ff[i][`EA_CTL_SEL_HI:`EA_CTL_SEL_LO] : 2'b00;
            if (i == `EA_SHARED_A || i == `EA_SHARED_B) begin : g_sh
                localparam int SH = i + (`EA_NUM_CH - `EA_NUM_CAP) - (`EA_SHARED_A - `EA_NUM_CAP + 2);
                assign act_sh = match[SH] ? ctl_ff[SH][`EA_CTL_SEL_HI:`EA_CTL_SEL_LO] : 2'b00;
            end else begin : g_ns
                assign act_sh = 2'b00;
            end
            assign nxt_pin[i] = apply_act(apply_act(o_pin_ff[i], act_own), act_sh);
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_pin_ff <= '0;
        end else begin
            o_pin_ff <= nxt_pin;
        end
    end

    // Action pulses
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_adc_start_ff <= 1'b0;
            o_t1_reset_ff  <= 1'b0;
            o_t2_reset_ff  <= 1'b0;
        end else begin
            o_adc_start_ff <= |adc_req;
            o_t1_reset_ff  <= |t1_req;
            o_t2_reset_ff  <= |t2_req;
        end
    end

    // Pending flags; a set beats a clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_main_pend_ff <= '0;
            o_src_pend_ff  <= '0;
            o_ovr_pend_ff  <= '0;
        end else begin
            o_main_pend_ff[`EA_NUM_DIRECT-1:0] <= (o_main_pend_ff[`EA_NUM_DIRECT-1:0] &
                ~i_main_clr[`EA_NUM_DIRECT-1:0]) | ev[`EA_NUM_DIRECT-1:0];
            o_main_pend_ff[`EA_MUX_BIT] <= (o_main_pend_ff[`EA_MUX_BIT] && !i_main_clr[`EA_MUX_BIT]) ||
                (|ev[`EA_NUM_CH-1:`EA_NUM_DIRECT]) || (|cap_ovr);
            o_src_pend_ff <= (o_src_pend_ff & ~i_src_clr) | ev[`EA_NUM_CH-1:`EA_NUM_DIRECT];
            o_ovr_pend_ff <= (o_ovr_pend_ff & ~i_ovr_clr) | cap_ovr;
        end
    end

    // Event-time read port
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_rd_data_ff <= `EA_TIME_RST;
        end else if (i_rd_time) begin
            o_rd_data_ff <= cmp_time_ff[i_rd_chan];
            for (int k = 0; k < `EA_NUM_CAP; k++) begin
                if (i_rd_chan == `EA_CHAN_W'(k) && !cmp_mode[k]) begin
                    o_rd_data_ff <= cap_time[k];
                end
            end
        end
    end

    assign o_rd_data   = o_rd_data_ff;
    assign o_pin       = o_pin_ff;
    assign o_adc_start = o_adc_start_ff;
    assign o_t1_reset  = o_t1_reset_ff;
    assign o_t2_reset  = o_t2_reset_ff;
    assign o_main_pend = o_main_pend_ff;
    assign o_src_pend  = o_src_pend_ff;
    assign o_ovr_pend  = o_ovr_pend_ff;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    property p_pend_direct;
        ev[0] |=> o_main_pend_ff[0];
    endproperty
    a_pend_direct: assert property (p_pend_direct) else $error("channel 0 event lost");
    property p_mux_pend;
        ev[10] |=> o_main_pend_ff[`EA_MUX_BIT] && o_src_pend_ff[6];
    endproperty
    a_mux_pend: assert property (p_mux_pend) else $error("compare-only event not on shared pending");
    property p_set_pin;
        (match[10] && ctl_ff[10][`EA_CTL_SEL_HI:`EA_CTL_SEL_LO] == 2'b10) |=> o_pin_ff[`EA_SHARED_A];
    endproperty
    a_set_pin: assert property (p_set_pin) else $error("set action did not raise shared pin");
    property p_toggle_pin;
        (match[1] && ctl_ff[1][`EA_CTL_SEL_HI:`EA_CTL_SEL_LO] == 2'b11) |=> o_pin_ff[1] != $past(o_pin_ff[1]);
    endproperty
    a_toggle_pin: assert property (p_toggle_pin) else $error("toggle action did not flip pin");
    property p_oneshot;
        (match[1] && !ctl_ff[1][`EA_CTL_REEN] && !i_wr_time) |=> !armed_ff[1] ##1 !match[1];
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot compare re-armed itself");
    property p_adc;
        (ev[1] && ctl_ff[1][`EA_CTL_ADC]) |=> o_adc_start_ff;
    endproperty
    a_adc: assert property (p_adc) else $error("A/D start missing after event");
    property p_ovr;
        cap_ovr[0] |=> o_ovr_pend_ff[0] && o_main_pend_ff[`EA_MUX_BIT];
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");
    property p_cmp_only;
        match[10] |=> o_src_pend_ff[6];
    endproperty
    a_cmp_only: assert property (p_cmp_only) else $error("compare-only event not pending");
    property p_reset_own;
        (match[1] && ctl_ff[1][`EA_CTL_TSEL] && ctl_ff[1][`EA_CTL_RST_OWN]) |=> o_t2_reset_ff;
    endproperty
    a_reset_own: assert property (p_reset_own) else $error("own timer reset missing after match");
    property p_reset_other;
        (ev[1] && ctl_ff[1][`EA_CTL_TSEL] && ctl_ff[1][`EA_CTL_RST_OTH]) |=> o_t1_reset_ff;
    endproperty
    a_reset_other: assert property (p_reset_other) else $error("other timer reset missing after event");
    property p_rd_cap;
        (i_rd_time && i_rd_chan == `EA_CHAN_W'(0) && !cmp_mode[0]) |=> o_rd_data_ff == $past(cap_time[0]);
    endproperty
    a_rd_cap: assert property (p_rd_cap) else $error("capture read returned wrong time");
    c_shared: cover property (match[`EA_SHARED_A] && match[10]);
    c_cap: cover property (g_ch[0].g_cap.u_cif.edge_ok);
    c_reset_t1: cover property (o_t1_reset_ff);
endmodule
`default_nettype wire

/* verification/pin_model.sv */
// Far-side pin driver: capture pins that hold each level steady
`default_nettype none
module pin_model (
    input  wire logic       i_mclk, // State clock
    input  wire logic [9:0] i_want, // Requested pin levels
    output var  logic [9:0] o_pin   // Pin levels seen by the array
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold = 0;
    initial o_pin = 10'h000;
    // Levels stay put for several state times around each change
    always @(negedge i_mclk) begin
        if (hold > 0) begin
            hold--;
        end else if (i_want !== o_pin) begin
            o_pin <= i_want;
            hold = 4;
        end
    end
endmodule
`default_nettype wire

/* verification/event_array_channels_test.sv */
// Self-checking bench for the event channel array
`default_nettype none
module event_array_channels_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 0, rst_b = 0, wr_ctl = 0, wr_time = 0, rd_time = 0;
    logic [15:0] t1 = 16'h0000, t2 = 16'h0000, wr_data = 16'h0000, rd_data;
    logic [3:0]  wr_chan = 4'h0, rd_chan = 4'h0;
    logic [9:0]  want = 10'h000, pin, out_pin, ovr_pend;
    logic [4:0]  main_clr = 5'h00, main_pend;
    logic [7:0]  src_pend;
    logic [7:0]  src_clr = 8'h00;
    logic [9:0]  ovr_clr = 10'h000;
    logic        adc, t1_rst, t2_rst;
    int          miscompares = 0, n_tests = 0, cyc = 0, n_adc = 0, n_t1r = 0, n_t2r = 0;
    always #2.5 mclk = ~mclk;
    always @(negedge mclk) t1 <= t1 + 16'h0001;
    pin_model pin_model_i (.i_mclk(mclk), .i_want(want), .o_pin(pin));
    event_array_channels event_array_channels_i (
        .i_mclk(mclk), .i_rst_b(rst_b), .i_timer1(t1), .i_timer2(t2), .i_pin(pin),
        .i_wr_ctl(wr_ctl), .i_wr_time(wr_time), .i_wr_chan(wr_chan), .i_wr_data(wr_data),
        .i_rd_time(rd_time), .i_rd_chan(rd_chan), .i_src_clr(src_clr), .i_ovr_clr(ovr_clr),
        .i_main_clr(main_clr), .o_rd_data(rd_data), .o_pin(out_pin), .o_adc_start(adc),
        .o_t1_reset(t1_rst), .o_t2_reset(t2_rst), .o_main_pend(main_pend), .o_src_pend(src_pend),
        .o_ovr_pend(ovr_pend));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic ctl, input logic [3:0] ch, input logic [15:0] d);
        @(negedge mclk);
        wr_ctl = ctl;
        wr_time = !ctl;
        wr_chan = ch;
        wr_data = d;
        @(negedge mclk);
        wr_ctl = 0;
        wr_time = 0;
    endtask
    task automatic rd(input logic [3:0] ch, input logic [15:0] exp);
        @(negedge mclk);
        rd_time = 1;
        rd_chan = ch;
        @(negedge mclk);
        rd_time = 0;
        @(negedge mclk);
        chk(rd_data, exp);
    endtask
    task automatic pin_step(input logic [15:0] tv, input logic lvl);
        @(negedge mclk);
        t2 = tv;
        want[0] = lvl;
        repeat (12) @(negedge mclk);
    endtask
    // Count one-cycle action pulses mid-cycle, while they stand
    always @(negedge mclk) begin
        n_adc = n_adc + int'(adc === 1'b1);
        n_t1r = n_t1r + int'(t1_rst === 1'b1);
        n_t2r = n_t2r + int'(t2_rst === 1'b1);
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            give_verdict;
        end
    end
    initial begin
        repeat (6) @(negedge mclk);
        rst_b = 1;
        // Capture on both edges against timer 2, overwrite off
        wr(1'b1, 4'h0, 16'h00B0);
        pin_step(16'h1111, 1'b1);
        chk({15'h0000, main_pend[0]}, 16'h0001);
        pin_step(16'h2222, 1'b0);
        chk({15'h0000, ovr_pend[0]}, 16'h0000);
        pin_step(16'h3333, 1'b1);
        chk({15'h0000, ovr_pend[0]}, 16'h0001);
        @(negedge mclk);
        main_clr = 5'h01;
        ovr_clr = 10'h001;
        @(negedge mclk);
        main_clr = 5'h00;
        ovr_clr = 10'h000;
        repeat (2) @(negedge mclk);
        chk({15'h0000, main_pend[0]}, 16'h0000);
        chk({15'h0000, ovr_pend[0]}, 16'h0000);
        rd(4'h0, 16'h1111);
        repeat (3) @(negedge mclk);
        chk({15'h0000, main_pend[0]}, 16'h0001);
        rd(4'h0, 16'h2222);
        // Compare-only channel 0 sets the shared pin on a timer 1 match
        wr(1'b1, 4'hA, 16'h0060);
        wr(1'b0, 4'hA, t1 + 16'h0020);
        repeat (40) @(negedge mclk);
        chk({15'h0000, out_pin[8]}, 16'h0001);
        chk({15'h0000, src_pend[6]}, 16'h0001);
        // Channel 1 compare on timer 2: toggle, A/D start, reset both timers, one-shot
        wr(1'b1, 4'h1, 16'h01F6);
        wr(1'b0, 4'h1, 16'h4444);
        pin_step(16'h4444, 1'b1);
        chk({15'h0000, out_pin[1]}, 16'h0001);
        chk({15'h0000, main_pend[1]}, 16'h0001);
        chk(16'(n_adc), 16'h0001);
        chk(16'(n_t1r), 16'h0001);
        chk(16'(n_t2r), 16'h0001);
        // Second equality without a time write does nothing
        pin_step(16'h0000, 1'b1);
        pin_step(16'h4444, 1'b1);
        chk(16'(n_adc), 16'h0001);
        // A fresh time write re-arms the channel
        pin_step(16'h0000, 1'b1);
        wr(1'b0, 4'h1, 16'h4444);
        pin_step(16'h4444, 1'b1);
        chk({15'h0000, out_pin[1]}, 16'h0000);
        chk(16'(n_adc), 16'h0002);
        // Source pending clears on its own pulse
        src_clr = 8'h40;
        @(negedge mclk);
        src_clr = 8'h00;
        @(negedge mclk);
        chk({15'h0000, src_pend[6]}, 16'h0000);
        // Mid-run reset clears pins and pending flags
        rst_b = 0;
        repeat (2) @(negedge mclk);
        rst_b = 1;
        repeat (2) @(negedge mclk);
        chk({3'h0, main_pend, src_pend}, 16'h0000);
        chk({6'h00, out_pin}, 16'h0000);
        give_verdict;
    end
endmodule
`default_nettype wire
